// >>> bsc_regs.svh
// bsc_regs.svh: codes, capture values and widths of the boundary-scan test port
// assumes: included by its bare name from the package and the top module
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

`define BSC_IR_W          4
`define BSC_IR_EXTERNAL   4'h0
`define BSC_IR_SAMPLE     4'h1
`define BSC_IR_IDENT      4'h2
`define BSC_IR_FLOAT      4'h3
`define BSC_IR_BYPASS     4'hF
`define BSC_IR_CAPTURE    4'h1
`define BSC_IR_RESET      4'h2
`define BSC_ID_W          32
`define BSC_ID_VER_W      4
`define BSC_ID_PART_W     16
`define BSC_ID_MAKER_W    11
`define BSC_ID_FIXED_ONE  1'h1
`define BSC_BYPASS_CAPT   1'h0
`define BSC_SYNC_W        2

`endif

// >>> bsc_pkg.sv
// bsc_pkg.sv: types of the boundary-scan test port
// assumes: bsc_regs.svh is on the include path
`default_nettype none
`include "bsc_regs.svh"
package bsc_pkg;

  typedef enum logic [3:0] {
    TEST_RESET = 4'h0,
    RUN_IDLE   = 4'h1,
    SEL_DR     = 4'h2,
    CAPT_DR    = 4'h3,
    SHIFT_DR   = 4'h4,
    EXIT1_DR   = 4'h5,
    PAUSE_DR   = 4'h6,
    EXIT2_DR   = 4'h7,
    UPD_DR     = 4'h8,
    SEL_IR     = 4'h9,
    CAPT_IR    = 4'hA,
    SHIFT_IR   = 4'hB,
    EXIT1_IR   = 4'hC,
    PAUSE_IR   = 4'hD,
    EXIT2_IR   = 4'hE,
    UPD_IR     = 4'hF
  } bsc_state_t;

  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_BOUND  = 2'h1,
    PATH_IDENT  = 2'h2
  } bsc_path_t;

endpackage
`default_nettype wire

// >>> bsc_tap.sv
// bsc_tap.sv: boundary-scan test access port with tap state machine,
// instruction register, bypass, identification and boundary register.
// assumes: test clock and system clock unrelated; pins and core on system clock.
//
// Functional notes
// - five tms-high edges reach test reset
// - tap wins; core waits until tap reset
// - state moves only on rising tck, by tms
// - capture-dr loads register from pins/core
// - shift lsb first; tdo on falling tck
// - update-dr copies shift stage to latches
// - exit with tms high updates; others hold
// - pause-dr halts shifting, registers hold
// - ir states mirror their dr counterparts
// - instruction takes effect at update-ir; test reset loads code 2
// - four-bit instruction, lsb nearest tdo
// - codes 0 and 1 select boundary register
// - code 2 selects identification register
// - code F selects single-stage bypass
// - code 3 floats every output pin
// - bypass stage cleared in capture-dr
// - unselected registers leave operation alone
// - id: version, part, maker, bit0 one
// - instruction picks the serial data path
// - sample snapshots pins, preloads latches
// - registers parallel on one tdi/tdo
`include "bsc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bsc_tap #(
  parameter int                            N_IN    = 4,
  parameter int                            N_OUT   = 4,
  parameter logic [`BSC_ID_VER_W-1:0]      ID_VER  = 4'h1,    // arbitrary
  parameter logic [`BSC_ID_PART_W-1:0]     ID_PART = 16'h1234, // arbitrary
  parameter logic [`BSC_ID_MAKER_W-1:0]    ID_MAKER = 11'h055 // arbitrary
) (
  input  wire logic             I_REF_CLK,
  input  wire logic             I_SYS_RST,
  input  wire logic             I_TCK,
  input  wire logic             I_TMS,
  input  wire logic             I_TDI,
  input  wire logic             I_TRST_N,
  output var  logic             O_TDO,
  output var  logic             O_TDO_OE,
  input  wire logic [N_IN-1:0]  I_PIN_IN,
  input  wire logic [N_OUT-1:0] I_CORE_OUT,
  output var  logic [N_OUT-1:0] O_PIN_OUT,
  output var  logic             O_PIN_OE,
  output var  logic [N_IN-1:0]  O_CORE_IN,
  output var  logic             O_TAP_READY
);

  localparam int BW = N_IN + N_OUT;

  generate
    if (N_IN < 1 || N_OUT < 1) begin : g_chk
      $error("bsc_tap: N_IN and N_OUT must be at least 1");
    end
  endgenerate

  // ---------------- test clock domain ----------------
  bsc_pkg::bsc_state_t state_reg;
  bsc_pkg::bsc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bsc_pkg::TEST_RESET: state_next = I_TMS ? bsc_pkg::TEST_RESET : bsc_pkg::RUN_IDLE;
      bsc_pkg::RUN_IDLE:   state_next = I_TMS ? bsc_pkg::SEL_DR : bsc_pkg::RUN_IDLE;
      bsc_pkg::SEL_DR:     state_next = I_TMS ? bsc_pkg::SEL_IR : bsc_pkg::CAPT_DR;
      bsc_pkg::CAPT_DR:    state_next = I_TMS ? bsc_pkg::EXIT1_DR : bsc_pkg::SHIFT_DR;
      bsc_pkg::SHIFT_DR:   state_next = I_TMS ? bsc_pkg::EXIT1_DR : bsc_pkg::SHIFT_DR;
      bsc_pkg::EXIT1_DR:   state_next = I_TMS ? bsc_pkg::UPD_DR : bsc_pkg::PAUSE_DR;
      bsc_pkg::PAUSE_DR:   state_next = I_TMS ? bsc_pkg::EXIT2_DR : bsc_pkg::PAUSE_DR;
      bsc_pkg::EXIT2_DR:   state_next = I_TMS ? bsc_pkg::UPD_DR : bsc_pkg::SHIFT_DR;
      bsc_pkg::UPD_DR:     state_next = I_TMS ? bsc_pkg::SEL_DR : bsc_pkg::RUN_IDLE;
      bsc_pkg::SEL_IR:     state_next = I_TMS ? bsc_pkg::TEST_RESET : bsc_pkg::CAPT_IR;
      bsc_pkg::CAPT_IR:    state_next = I_TMS ? bsc_pkg::EXIT1_IR : bsc_pkg::SHIFT_IR;
      bsc_pkg::SHIFT_IR:   state_next = I_TMS ? bsc_pkg::EXIT1_IR : bsc_pkg::SHIFT_IR;
      bsc_pkg::EXIT1_IR:   state_next = I_TMS ? bsc_pkg::UPD_IR : bsc_pkg::PAUSE_IR;
      bsc_pkg::PAUSE_IR:   state_next = I_TMS ? bsc_pkg::EXIT2_IR : bsc_pkg::PAUSE_IR;
      bsc_pkg::EXIT2_IR:   state_next = I_TMS ? bsc_pkg::UPD_IR : bsc_pkg::SHIFT_IR;
      bsc_pkg::UPD_IR:     state_next = I_TMS ? bsc_pkg::SEL_DR : bsc_pkg::RUN_IDLE;
    endcase
  end

  // rising tck only; trst low is asynchronous
  always_ff @(posedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      state_reg <= bsc_pkg::TEST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // pins and core outputs captured on the test clock pass two flops first
  logic [BW-1:0] cap_s1_reg;
  logic [BW-1:0] cap_s2_reg;
  logic [BW-1:0] cap_s1_next;
  logic [BW-1:0] cap_s2_next;

  always_comb begin
    cap_s1_next = {I_CORE_OUT, I_PIN_IN};
    cap_s2_next = cap_s1_reg;
  end

  always_ff @(posedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      cap_s1_reg <= '0;
      cap_s2_reg <= '0;
    end else begin
      cap_s1_reg <= cap_s1_next;
      cap_s2_reg <= cap_s2_next;
    end
  end

  // instruction and data registers
  logic [`BSC_IR_W-1:0]  ir_sh_reg;
  logic [`BSC_IR_W-1:0]  ir_sh_next;
  logic [`BSC_IR_W-1:0]  ir_reg;
  logic [`BSC_IR_W-1:0]  ir_next;
  logic                  byp_reg;
  logic                  byp_next;
  logic [`BSC_ID_W-1:0]  id_sh_reg;
  logic [`BSC_ID_W-1:0]  id_sh_next;
  logic [BW-1:0]         bsr_sh_reg;
  logic [BW-1:0]         bsr_sh_next;
  logic [BW-1:0]         bsr_upd_reg;
  logic [BW-1:0]         bsr_upd_next;
  logic                  upd_tgl_reg;
  logic                  upd_tgl_next;
  logic                  seen_rst_reg;
  logic                  seen_rst_next;
  bsc_pkg::bsc_path_t    path;
  logic [`BSC_ID_W-1:0]  id_value;

  assign id_value = {ID_VER, ID_PART, ID_MAKER, `BSC_ID_FIXED_ONE};

  always_comb begin
    unique case (ir_reg)
      `BSC_IR_EXTERNAL: path = bsc_pkg::PATH_BOUND;
      `BSC_IR_SAMPLE:   path = bsc_pkg::PATH_BOUND;
      `BSC_IR_IDENT:    path = bsc_pkg::PATH_IDENT;
      default:          path = bsc_pkg::PATH_BYPASS;
    endcase
  end

  always_comb begin
    ir_sh_next    = ir_sh_reg;
    ir_next       = ir_reg;
    byp_next      = byp_reg;
    id_sh_next    = id_sh_reg;
    bsr_sh_next   = bsr_sh_reg;
    bsr_upd_next  = bsr_upd_reg;
    upd_tgl_next  = upd_tgl_reg;
    seen_rst_next = seen_rst_reg | (state_reg == bsc_pkg::TEST_RESET);
    unique case (state_reg)
      bsc_pkg::TEST_RESET: ir_next = `BSC_IR_RESET;
      bsc_pkg::CAPT_IR:    ir_sh_next = `BSC_IR_CAPTURE;
      bsc_pkg::SHIFT_IR:   ir_sh_next = {I_TDI, ir_sh_reg[`BSC_IR_W-1:1]};
      bsc_pkg::UPD_IR:     ir_next = ir_sh_reg;
      bsc_pkg::CAPT_DR: begin
        unique case (path)
          bsc_pkg::PATH_BYPASS: byp_next = `BSC_BYPASS_CAPT;
          bsc_pkg::PATH_IDENT:  id_sh_next = id_value;
          bsc_pkg::PATH_BOUND:  bsr_sh_next = cap_s2_reg;
        endcase
      end
      bsc_pkg::SHIFT_DR: begin
        unique case (path)
          bsc_pkg::PATH_BYPASS: byp_next = I_TDI;
          bsc_pkg::PATH_IDENT:  id_sh_next = {I_TDI, id_sh_reg[`BSC_ID_W-1:1]};
          bsc_pkg::PATH_BOUND:  bsr_sh_next = {I_TDI, bsr_sh_reg[BW-1:1]};
        endcase
      end
      bsc_pkg::UPD_DR: begin
        if (path == bsc_pkg::PATH_BOUND) begin
          bsr_upd_next = bsr_sh_reg;
          upd_tgl_next = ~upd_tgl_reg;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      ir_sh_reg    <= `BSC_IR_RESET;
      ir_reg       <= `BSC_IR_RESET;
      byp_reg      <= `BSC_BYPASS_CAPT;
      id_sh_reg    <= '0;
      bsr_sh_reg   <= '0;
      bsr_upd_reg  <= '0;
      upd_tgl_reg  <= 1'h0;
      seen_rst_reg <= 1'h1;
    end else begin
      ir_sh_reg    <= ir_sh_next;
      ir_reg       <= ir_next;
      byp_reg      <= byp_next;
      id_sh_reg    <= id_sh_next;
      bsr_sh_reg   <= bsr_sh_next;
      bsr_upd_reg  <= bsr_upd_next;
      upd_tgl_reg  <= upd_tgl_next;
      seen_rst_reg <= seen_rst_next;
    end
  end

  // serial output changes on the falling test clock edge
  logic tdo_reg;
  logic tdo_next;
  logic tdo_oe_reg;
  logic tdo_oe_next;

  always_comb begin
    tdo_next    = tdo_reg;
    tdo_oe_next = 1'h0;
    if (state_reg == bsc_pkg::SHIFT_IR) begin
      tdo_next    = ir_sh_reg[0];
      tdo_oe_next = 1'h1;
    end else if (state_reg == bsc_pkg::SHIFT_DR) begin
      tdo_oe_next = 1'h1;
      unique case (path)
        bsc_pkg::PATH_BYPASS: tdo_next = byp_reg;
        bsc_pkg::PATH_IDENT:  tdo_next = id_sh_reg[0];
        bsc_pkg::PATH_BOUND:  tdo_next = bsr_sh_reg[0];
      endcase
    end
  end

  always_ff @(negedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      tdo_reg    <= 1'h0;
      tdo_oe_reg <= 1'h0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign O_TDO    = tdo_reg;
  assign O_TDO_OE = tdo_oe_reg;

  // instruction flags held as levels for the system side;
  // taken from ir_next so a stopped tck cannot leave them stale
  logic ext_reg;
  logic ext_next;
  logic flt_reg;
  logic flt_next;

  always_comb begin
    ext_next = (ir_next == `BSC_IR_EXTERNAL);
    flt_next = (ir_next == `BSC_IR_FLOAT);
  end

  always_ff @(posedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      ext_reg <= 1'h0;
      flt_reg <= 1'h0;
    end else begin
      ext_reg <= ext_next;
      flt_reg <= flt_next;
    end
  end

  // ---------------- system clock domain ----------------
  // levels and the update toggle cross through two flops
  logic [`BSC_SYNC_W-1:0] ext_sy_reg;
  logic [`BSC_SYNC_W-1:0] ext_sy_next;
  logic [`BSC_SYNC_W-1:0] flt_sy_reg;
  logic [`BSC_SYNC_W-1:0] flt_sy_next;
  logic [`BSC_SYNC_W-1:0] rdy_sy_reg;
  logic [`BSC_SYNC_W-1:0] rdy_sy_next;
  logic [`BSC_SYNC_W-1:0] tgl_sy_reg;
  logic [`BSC_SYNC_W-1:0] tgl_sy_next;
  logic                   tgl_seen_reg;
  logic                   tgl_seen_next;
  logic [N_IN-1:0]        pin_s1_reg;
  logic [N_IN-1:0]        pin_s1_next;
  logic [N_IN-1:0]        pin_s2_reg;
  logic [N_IN-1:0]        pin_s2_next;
  logic [BW-1:0]          upd_copy_reg;
  logic [BW-1:0]          upd_copy_next;

  always_comb begin
    ext_sy_next   = {ext_sy_reg[0], ext_reg};
    flt_sy_next   = {flt_sy_reg[0], flt_reg};
    rdy_sy_next   = {rdy_sy_reg[0], seen_rst_reg};
    tgl_sy_next   = {tgl_sy_reg[0], upd_tgl_reg};
    tgl_seen_next = tgl_sy_reg[1];
    pin_s1_next   = I_PIN_IN;
    pin_s2_next   = pin_s1_reg;
    upd_copy_next = upd_copy_reg;
    // latch contents are stable for many test clocks after the toggle
    if (tgl_sy_reg[1] != tgl_seen_reg) begin
      upd_copy_next = bsr_upd_reg;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ext_sy_reg   <= '0;
      flt_sy_reg   <= '0;
      rdy_sy_reg   <= '0;
      tgl_sy_reg   <= '0;
      tgl_seen_reg <= 1'h0;
      pin_s1_reg   <= '0;
      pin_s2_reg   <= '0;
      upd_copy_reg <= '0;
    end else begin
      ext_sy_reg   <= ext_sy_next;
      flt_sy_reg   <= flt_sy_next;
      rdy_sy_reg   <= rdy_sy_next;
      tgl_sy_reg   <= tgl_sy_next;
      tgl_seen_reg <= tgl_seen_next;
      pin_s1_reg   <= pin_s1_next;
      pin_s2_reg   <= pin_s2_next;
      upd_copy_reg <= upd_copy_next;
    end
  end

  // pin-facing muxes, one cell per bit
  logic [N_OUT-1:0] pin_out_reg;
  logic [N_OUT-1:0] pin_out_next;
  logic [N_IN-1:0]  core_in_reg;
  logic [N_IN-1:0]  core_in_next;
  logic             pin_oe_reg;
  logic             pin_oe_next;
  logic             ready_reg;
  logic             ready_next;

  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      // external test drives the preloaded latch, otherwise the core
      assign pin_out_next[gi] = ext_sy_reg[1] ? upd_copy_reg[N_IN + gi]
                                              : I_CORE_OUT[gi];
    end
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign core_in_next[gi] = ext_sy_reg[1] ? upd_copy_reg[gi]
                                              : pin_s2_reg[gi];
    end
  endgenerate

  always_comb begin
    pin_oe_next = rdy_sy_reg[1] & ~flt_sy_reg[1];
    ready_next  = rdy_sy_reg[1];
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_out_reg <= '0;
      core_in_reg <= '0;
      pin_oe_reg  <= 1'h0;
      ready_reg   <= 1'h0;
    end else begin
      pin_out_reg <= pin_out_next;
      core_in_reg <= core_in_next;
      pin_oe_reg  <= pin_oe_next;
      ready_reg   <= ready_next;
    end
  end

  assign O_PIN_OUT   = pin_out_reg;
  assign O_CORE_IN   = core_in_reg;
  assign O_PIN_OE    = pin_oe_reg;
  assign O_TAP_READY = ready_reg;

endmodule
`default_nettype wire

// >>> bsc_tap_monitor.sv
// bsc_tap_monitor.sv: port assertions for the boundary-scan test port
// assumes: bound to bsc_tap; shadows tap state and instruction from tck, tms, tdi
`timescale 1ns/1ps
`default_nettype none
module bsc_tap_monitor #(
  parameter int N_IN  = 4,
  parameter int N_OUT = 4
) (
  input wire logic             I_REF_CLK,
  input wire logic             I_SYS_RST,
  input wire logic             I_TCK,
  input wire logic             I_TMS,
  input wire logic             I_TDI,
  input wire logic             I_TRST_N,
  input wire logic             O_TDO,
  input wire logic             O_TDO_OE,
  input wire logic [N_IN-1:0]  I_PIN_IN,
  input wire logic [N_OUT-1:0] I_CORE_OUT,
  input wire logic [N_OUT-1:0] O_PIN_OUT,
  input wire logic             O_PIN_OE,
  input wire logic [N_IN-1:0]  O_CORE_IN,
  input wire logic             O_TAP_READY
);
  // next state per state nibble, tms high and tms low
  localparam logic [63:0] NXT_HI = 64'h2FEFCC0287855920;
  localparam logic [63:0] NXT_LO = 64'h1BDDBBA146644311;
  logic [3:0] st_reg;
  logic [3:0] st_next;
  logic [3:0] ir_reg;
  logic [3:0] ir_next;
  logic [3:0] sh_reg;
  logic [3:0] sh_next;
  logic       byp;
  assign byp = ir_reg > 4'h2;
  always_comb begin
    st_next = I_TMS ? NXT_HI[{st_reg, 2'h0} +: 4] : NXT_LO[{st_reg, 2'h0} +: 4];
    sh_next = st_reg == 4'hA ? 4'h1 : (st_reg == 4'hB ? {I_TDI, sh_reg[3:1]} : sh_reg);
    ir_next = st_reg == 4'hF ? sh_reg : (st_reg == 4'h0 ? 4'h2 : ir_reg);
  end
  always_ff @(posedge I_TCK or negedge I_TRST_N) begin
    if (!I_TRST_N) begin
      st_reg <= 4'h0;
      ir_reg <= 4'h2;
      sh_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      ir_reg <= ir_next;
      sh_reg <= sh_next;
    end
  end
  sequence s_dr_start;
    st_reg == 4'h4 && $past(st_reg) == 4'h3;
  endsequence
  sequence s_ir_start;
    st_reg == 4'hB && $past(st_reg) == 4'hA;
  endsequence
  a_trst_quiet: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!I_TRST_N)[*2] |-> !O_TDO_OE && !O_TDO) else $error("tdo active under test reset");
  a_tms_five: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    I_TMS[*5] |-> ##1 !O_TDO_OE) else $error("five tms highs did not reset");
  a_oe_state: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    O_TDO_OE == (st_reg == 4'h4 || st_reg == 4'hB)) else $error("tdo enable off state");
  a_tdo_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_TRST_N)
    I_TCK && $past(I_TCK) |-> $stable(O_TDO) && $stable(O_TDO_OE)) else $error("tdo moved on tck high");
  a_bypass_path: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    byp && st_reg == 4'h4 && $past(st_reg) == 4'h4 |-> O_TDO == $past(I_TDI)) else $error("bypass path wrong");
  a_bypass_zero: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    byp and s_dr_start |-> !O_TDO) else $error("bypass not cleared");
  a_ident_lsb: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    (ir_reg == 4'h2) and s_dr_start |-> O_TDO) else $error("id bit0 not one");
  a_ir_capture: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    s_ir_start |-> O_TDO ##1 (st_reg != 4'hB || !O_TDO)) else $error("ir capture pattern wrong");
  a_float_pins: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (ir_reg == 4'h3)[*8] |-> !O_PIN_OE) else $error("pins driven under float");
  a_drive_pins: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (ir_reg != 4'h3 && O_TAP_READY)[*8] |-> O_PIN_OE) else $error("pins not driven");
  a_ready_late: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    $fell(I_SYS_RST) |-> (!O_TAP_READY && !O_PIN_OE)[*2]) else $error("ready too early");
endmodule
bind bsc_tap bsc_tap_monitor #(.N_IN(N_IN), .N_OUT(N_OUT)) u_mon (.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
  .I_TCK(I_TCK), .I_TMS(I_TMS), .I_TDI(I_TDI), .I_TRST_N(I_TRST_N), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
  .I_PIN_IN(I_PIN_IN), .I_CORE_OUT(I_CORE_OUT), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE),
  .O_CORE_IN(O_CORE_IN), .O_TAP_READY(O_TAP_READY));
`default_nettype wire

// >>> bsc_jtag_ctl.sv
// bsc_jtag_ctl.sv: behavioural board test controller for the tap
// assumes: tasks called by the bench; tck idles low between frames
`timescale 1ns/1ps
`default_nettype none
module bsc_jtag_ctl (
  output var  logic o_tck,
  output var  logic o_tms,
  output var  logic o_tdi,
  output var  logic o_trst_n,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  // one 80 ns tck period; tdo taken at the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #20;
    o_tck = 1'b1;
    tdo = i_tdo;
    #40;
    o_tck = 1'b0;
    #20;
  endtask
  task automatic hard_reset;
    logic b;
    #7.3;
    o_trst_n = 1'b0;
    #100;
    o_trst_n = 1'b1;
    #30;
    tick(1'b0, ~o_tdi, b);
  endtask
  task automatic tms_reset;
    logic b;
    repeat (5) tick(1'b1, ~o_tdi, b);
    tick(1'b0, ~o_tdi, b);
  endtask
  // from run-idle; slow pauses before the last bit
  task automatic scan(input logic ir, input int n, input logic slow, input logic [63:0] din,
                      output logic [63:0] dout);
    logic b;
    int   i;
    dout = '0;
    tick(1'b1, ~o_tdi, b);
    if (ir) tick(1'b1, ~o_tdi, b);
    tick(1'b0, ~o_tdi, b);
    tick(1'b0, ~o_tdi, b);
    for (i = 0; i < n; i++) begin
      if (slow && i == n - 2) begin
        tick(1'b1, din[i], dout[i]);
        tick(1'b0, ~o_tdi, b);
        tick(1'b0, ~o_tdi, b);
        tick(1'b1, ~o_tdi, b);
        tick(1'b0, ~o_tdi, b);
      end else begin
        tick(i == n - 1, din[i], dout[i]);
      end
    end
    tick(1'b1, ~o_tdi, b);
    tick(1'b0, ~o_tdi, b);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the boundary-scan test port
// assumes: controller model drives the link; checker bound to the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h055, 1'h1}; // arbitrary identity
  logic        ref_clk, sys_rst, tck, tms, tdi, trst_n, tdo, tdo_oe, pin_oe, tap_ready;
  logic [3:0]  pin_in, core_out, pin_out, core_in, lat_in, lat_out;
  logic [63:0] exp_q[$];
  logic [63:0] got_q[$];
  logic [63:0] e, g, din, dout, ex;
  logic [3:0]  codes[7] = '{4'h1, 4'h0, 4'h2, 4'h3, 4'hF, 4'h5, 4'h0};
  int          mismatches, total_checks, cycles, seed, len;

  bsc_tap #(.ID_VER(4'h1), .ID_PART(16'h1234), .ID_MAKER(11'h055)) DUT (.I_REF_CLK(ref_clk),
    .I_SYS_RST(sys_rst), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_TRST_N(trst_n), .O_TDO(tdo),
    .O_TDO_OE(tdo_oe), .I_PIN_IN(pin_in), .I_CORE_OUT(core_out), .O_PIN_OUT(pin_out),
    .O_PIN_OE(pin_oe), .O_CORE_IN(core_in), .O_TAP_READY(tap_ready));
  bsc_jtag_ctl u_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic note(input logic [63:0] ev, input logic [63:0] gv);
    exp_q.push_back(ev);
    got_q.push_back(gv);
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic sys_check(input logic [3:0] c);
    repeat (12) @(posedge ref_clk);
    #2;
    note(64'(c != 4'h3), 64'(pin_oe));
    note(64'(c == 4'h0 ? lat_out : core_out), 64'(pin_out));
    note(64'(c == 4'h0 ? lat_in : pin_in), 64'(core_in));
  endtask

  initial begin
    forever begin
      wait (got_q.size() > 0);
      e = exp_q.pop_front();
      g = got_q.pop_front();
      total_checks++;
      if (e !== g) begin
        mismatches++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    seed = 78202;
    sys_rst = 1'b1;
    pin_in = 4'h0;
    core_out = 4'h0;
    repeat (3) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    u_ctl.hard_reset();
    u_ctl.scan(1'b0, 32, 1'b0, 64'h0, dout);
    note(64'(ID), dout);
    note(64'h1, 64'(tap_ready));
    u_ctl.scan(1'b1, 4, 1'b0, 64'hF, dout);
    note(64'h1, dout);
    din = 64'($random(seed) & 16'hFFFF);
    u_ctl.scan(1'b0, 16, 1'b1, din, dout);
    note({48'h0, din[14:0], 1'h0}, dout);
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk);
      #2;
      pin_in = 4'($random(seed));
      core_out = 4'($random(seed));
      u_ctl.scan(1'b1, 4, 1'b0, 64'(codes[k]), dout);
      sys_check(codes[k]);
      din = {$random(seed), $random(seed)};
      u_ctl.scan(1'b0, 40, k[0], din, dout);
      len = codes[k] < 4'h2 ? 8 : (codes[k] == 4'h2 ? 32 : 1);
      ex = codes[k] < 4'h2 ? 64'({core_out, pin_in}) : (codes[k] == 4'h2 ? 64'(ID) : 64'h0);
      note(((din << len) | ex) & 64'hFF_FFFF_FFFF, dout);
      if (codes[k] < 4'h2) begin
        lat_in = din[35:32];
        lat_out = din[39:36];
      end
      sys_check(codes[k]);
    end
    u_ctl.tms_reset();
    u_ctl.scan(1'b0, 32, 1'b0, 64'h0, dout);
    note(64'(ID), dout);
    sys_check(4'h2);
    wait (got_q.size() == 0);
    test_done();
  end
endmodule
`default_nettype wire
